//--- rtl/tsi_consts.svh
// constants of the two-wire slave port
`ifndef TSI_CONSTS_SVH
`define TSI_CONSTS_SVH
`define TSI_ADDR_FIXED   5'h0b
`define TSI_PTR_MAX      8'hff
`define TSI_BIT_LAST     3'h7
`define TSI_PTR_RESET    8'h00
`define TSI_WORD_RESET   16'h0000
`endif

//--- rtl/tsi_pkg.sv
// types of the two-wire slave port
package tsi_pkg;
	typedef enum logic [2:0] {
		TSI_IDLE,
		TSI_ADDR,
		TSI_ACK,
		TSI_WDATA,
		TSI_RDATA,
		TSI_RACK
	} tsi_state_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] data;
	} tsi_reg_req_t;
endpackage : tsi_pkg

//--- rtl/tsi_sync.sv
// two-flop synchroniser with registered edge detect for the bus pins
`timescale 1ns/1ns
module tsi_sync
	import tsi_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic pin_in,
	output logic      lvl,
	output logic      rise,
	output logic      fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// only sync_r reads meta_r; edges come from the two stable stages
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			last_r <= 1'b1;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign lvl  = last_r;
	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule : tsi_sync

//--- rtl/tsi_slave.sv
// two-wire serial slave port giving a master access to the sixteen-bit register map
// Function
// [RULE_01] answer only to address 01011 plus straps
// [RULE_02] straps drive address bits one and zero
// [RULE_03] slave only, never starts or clocks
// [RULE_04] data falling with clock high is start
// [RULE_05] shift eight bits msb first after start
// [RULE_06] acknowledge own address on ninth clock
// [RULE_07] direction 0 writes, 1 reads
// [RULE_08] nine clocks per byte, receiver acknowledges
// [RULE_09] master changes data only while clock low
// [RULE_10] stop returns device to idle
// [RULE_11] first write byte loads register pointer
// [RULE_12] write bytes pair high then low
// [RULE_13] pointer advances after each register write
// [RULE_14] pointer never wraps, writes at maximum dropped
// [RULE_15] master sends even number of data bytes
// [RULE_16] master sets pointer by write before reading
// [RULE_17] read returns high byte then low
// [RULE_18] reads advance pointer until master nacks
// [RULE_19] at maximum, reads repeat last register
// [RULE_20] master ends with stop or repeated start
// [RULE_21] repeated start keeps pointer, awaits address
// [RULE_22] unpaired high byte is dropped silently
`timescale 1ns/1ns
`include "tsi_consts.svh"
module tsi_slave
	import tsi_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	input  wire logic         addr_strap_bit0,
	input  wire logic         addr_strap_bit1,
	output tsi_reg_req_t      reg_req,
	output logic              reg_req_valid,
	input  wire logic [15:0]  reg_rdata,
	output logic [7:0]        reg_rd_addr,
	output logic              busy
);
	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;

	tsi_sync u_scl_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin_in  (scl_in),
		.lvl     (scl_lvl),
		.rise    (scl_rise),
		.fall    (scl_fall)
	);

	tsi_sync u_sda_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin_in  (sda_in),
		.lvl     (sda_lvl),
		.rise    (sda_rise),
		.fall    (sda_fall)
	);

	// straps are taken clocked; pins may be tied either way
	logic [1:0] strap_meta_r;
	logic [1:0] strap_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta_r <= 2'h0;
			strap_r      <= 2'h0;
		end else begin
			strap_meta_r <= {addr_strap_bit1, addr_strap_bit0};
			strap_r      <= strap_meta_r;
		end
	end

	logic [6:0] own_addr;
	assign own_addr = {`TSI_ADDR_FIXED, strap_r}; // [RULE_01] [RULE_02]

	logic start_det;
	logic stop_det;
	// scl_lvl is the delayed copy, so the level is sampled one cycle before the sample that shows the edge
	assign start_det = sda_fall & scl_lvl; // [RULE_04]
	assign stop_det  = sda_rise & scl_lvl; // [RULE_10]

	tsi_state_t   state_r;
	tsi_state_t   state_nxt;
	logic [2:0]   bit_r;
	logic [2:0]   bit_nxt;
	logic [7:0]   shift_r;
	logic [7:0]   shift_nxt;
	logic [7:0]   ptr_r;
	logic [7:0]   ptr_nxt;
	logic [7:0]   hi_r;
	logic [7:0]   hi_nxt;
	logic         have_ptr_r;
	logic         have_ptr_nxt;
	logic         have_hi_r;
	logic         have_hi_nxt;
	logic         rd_lo_r;
	logic         rd_lo_nxt;
	logic         ack_r;
	logic         ack_nxt;
	logic         drv_r;
	logic         drv_nxt;
	logic         sda_o_r;
	logic         sda_o_nxt;
	logic         nack_r;
	logic         nack_nxt;
	logic         dir_rd_r;
	logic         dir_rd_nxt;
	logic [7:0]   byte_in;
	logic [3:0]   rd_idx;
	logic         rd_bit;

	// the byte as it stands once its eighth bit is sampled
	assign byte_in = {shift_r[6:0], sda_lvl};

	// read bits go out high half first; the index wraps harmlessly on the ack slot
	always_comb begin
		rd_idx = rd_lo_r ? {1'b0, 3'h6 - bit_r} : 4'he - {1'b0, bit_r};
		rd_bit = reg_rdata[rd_idx];
	end

	tsi_reg_req_t req_r;
	tsi_reg_req_t req_nxt;
	logic         req_v_r;
	logic         req_v_nxt;

	always_comb begin
		state_nxt    = state_r;
		bit_nxt      = bit_r;
		shift_nxt    = shift_r;
		ptr_nxt      = ptr_r;
		hi_nxt       = hi_r;
		have_ptr_nxt = have_ptr_r;
		have_hi_nxt  = have_hi_r;
		rd_lo_nxt    = rd_lo_r;
		ack_nxt      = ack_r;
		drv_nxt      = drv_r;
		sda_o_nxt    = sda_o_r;
		nack_nxt     = nack_r;
		dir_rd_nxt   = dir_rd_r;
		req_nxt      = req_r;
		req_v_nxt    = 1'b0;
		if (stop_det) begin
			// an unpaired high byte simply never issues a write
			state_nxt   = TSI_IDLE; // [RULE_10] [RULE_22]
			have_hi_nxt = 1'b0;
			drv_nxt     = 1'b0;
		end else if (start_det) begin
			// repeated start leaves the pointer alone
			state_nxt   = TSI_ADDR; // [RULE_04] [RULE_21]
			bit_nxt     = 3'h0;
			have_hi_nxt = 1'b0; // [RULE_22]
			drv_nxt     = 1'b0;
		end else begin
			unique case (state_r)
				TSI_IDLE: begin
					drv_nxt = 1'b0;
				end
				TSI_ADDR, TSI_WDATA: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_lvl}; // [RULE_05] [RULE_08]
						bit_nxt   = bit_r + 3'h1;
						if (bit_r == `TSI_BIT_LAST) begin
							state_nxt = TSI_ACK;
							if (state_r == TSI_ADDR) begin
								ack_nxt      = (shift_r[6:0] == own_addr); // [RULE_06]
								have_ptr_nxt = 1'b0;
								rd_lo_nxt    = 1'b0;
								nack_nxt     = 1'b0;
								dir_rd_nxt   = sda_lvl; // [RULE_07]
							end else begin
								ack_nxt = 1'b1;
								if (!have_ptr_r) begin
									ptr_nxt      = byte_in; // [RULE_11]
									have_ptr_nxt = 1'b1;
								end else if (!have_hi_r) begin
									hi_nxt      = byte_in; // [RULE_12]
									have_hi_nxt = 1'b1;
								end else begin
									have_hi_nxt = 1'b0;
									if (ptr_r != `TSI_PTR_MAX) begin // [RULE_14]
										req_nxt.wr   = 1'b1;
										req_nxt.addr = ptr_r;
										req_nxt.data = {hi_r, byte_in}; // [RULE_12]
										req_v_nxt    = 1'b1;
										ptr_nxt      = ptr_r + 8'h01; // [RULE_13]
									end
								end
							end
						end
					end
				end
				TSI_ACK: begin
					// drive on the falling edge after the eighth bit, release after ninth
					if (scl_fall && !drv_r) begin
						drv_nxt   = ack_r; // [RULE_06] [RULE_08]
						sda_o_nxt = 1'b0;
						if (!ack_r) begin
							state_nxt = TSI_IDLE; // [RULE_06]
						end
					end else if (scl_fall && drv_r) begin
						drv_nxt = 1'b0;
						bit_nxt = 3'h0;
						// a read frame passes here only once, after its address byte
						if (dir_rd_r) begin
							state_nxt = TSI_RDATA; // [RULE_07]
							drv_nxt   = 1'b1;
							sda_o_nxt = reg_rdata[15]; // [RULE_17]
						end else begin
							state_nxt = TSI_WDATA; // [RULE_07]
						end
					end
				end
				TSI_RDATA: begin
					if (scl_fall) begin
						bit_nxt = bit_r + 3'h1;
						if (bit_r == `TSI_BIT_LAST) begin
							drv_nxt   = 1'b0;
							state_nxt = TSI_RACK;
						end else begin
							sda_o_nxt = rd_bit; // [RULE_17]
						end
					end
				end
				TSI_RACK: begin
					if (scl_rise) begin
						// a nack ends the read; the master then stops
						nack_nxt = sda_lvl; // [RULE_18]
						if (rd_lo_r && !sda_lvl && ptr_r != `TSI_PTR_MAX) begin
							ptr_nxt = ptr_r + 8'h01; // [RULE_18] [RULE_19]
						end
						if (!sda_lvl) begin
							rd_lo_nxt = ~rd_lo_r; // [RULE_17]
						end
					end else if (scl_fall) begin
						if (nack_r) begin
							state_nxt = TSI_IDLE; // [RULE_18]
						end else begin
							state_nxt = TSI_RDATA;
							bit_nxt   = 3'h0;
							drv_nxt   = 1'b1;
							sda_o_nxt = rd_lo_r ? reg_rdata[7] : reg_rdata[15]; // [RULE_17]
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= TSI_IDLE;
			bit_r      <= 3'h0;
			shift_r    <= 8'h00;
			ptr_r      <= `TSI_PTR_RESET;
			hi_r       <= 8'h00;
			have_ptr_r <= 1'b0;
			have_hi_r  <= 1'b0;
			rd_lo_r    <= 1'b0;
			ack_r      <= 1'b0;
			drv_r      <= 1'b0;
			sda_o_r    <= 1'b0;
			nack_r     <= 1'b0;
			dir_rd_r   <= 1'b0;
			req_r.wr   <= 1'b0;
			req_r.addr <= `TSI_PTR_RESET;
			req_r.data <= `TSI_WORD_RESET;
			req_v_r    <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			bit_r      <= bit_nxt;
			shift_r    <= shift_nxt;
			ptr_r      <= ptr_nxt;
			hi_r       <= hi_nxt;
			have_ptr_r <= have_ptr_nxt;
			have_hi_r  <= have_hi_nxt;
			rd_lo_r    <= rd_lo_nxt;
			ack_r      <= ack_nxt;
			drv_r      <= drv_nxt;
			sda_o_r    <= sda_o_nxt;
			nack_r     <= nack_nxt;
			dir_rd_r   <= dir_rd_nxt;
			req_r      <= req_nxt;
			req_v_r    <= req_v_nxt;
		end
	end

	// the clock pin is never driven; open drain means only low is ever driven
	assign sda_oe        = drv_r & ~sda_o_r; // [RULE_03]
	assign sda_out       = 1'b0;
	assign reg_req       = req_r;
	assign reg_req_valid = req_v_r;
	assign reg_rd_addr   = ptr_r; // [RULE_19]
	assign busy          = (state_r != TSI_IDLE);
endmodule : tsi_slave

//--- dv/tsi_slave_asserts.sv
// pin-level checker of the two-wire slave port
`timescale 1ns/1ns
module tsi_slave_asserts
	import tsi_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rst_n,
	input wire logic         scl_in,
	input wire logic         sda_in,
	input wire logic         sda_out,
	input wire logic         sda_oe,
	input wire tsi_reg_req_t reg_req,
	input wire logic         reg_req_valid,
	input wire logic [7:0]   reg_rd_addr,
	input wire logic         busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// bus edges reach the state machine two cycles late, plus its own registers
	sequence stop_s;
		scl_in && $rose(sda_in);
	endsequence
	AST_OPEN_DRAIN: assert property (sda_out == 1'b0) else $error("data driven high");
	AST_VALID_WR: assert property (reg_req_valid |-> reg_req.wr) else $error("write flag low");
	AST_VALID_PULSE: assert property (reg_req_valid |=> !reg_req_valid) else $error("long pulse");
	AST_NO_WRAP: assert property (reg_req_valid |-> reg_req.addr != 8'hff) else $error("write at top");
	AST_OE_BUSY: assert property (sda_oe |-> busy || $past(busy)) else $error("drive while idle");
	AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved");
	AST_STOP_IDLE: assert property (stop_s |-> ##[1:8] !busy) else $error("stop ignored");
	AST_START_BUSY: assert property (scl_in && $fell(sda_in) |-> ##[1:8] busy) else $error("no start");
	cover property (reg_req_valid);
	cover property (sda_oe && scl_in);
	cover property (busy ##1 !busy);
endmodule : tsi_slave_asserts

bind tsi_slave tsi_slave_asserts tsi_slave_asserts_i (.ref_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
	.reg_req, .reg_req_valid, .reg_rd_addr, .busy);

//--- dv/tsi_bus_master.sv
// two-wire bus master model; clock stands high between frames
`timescale 1ns/1ns
module tsi_bus_master (
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// 16 ns setup keeps four core cycles before each clock rise
	task automatic xbit(input logic b, output logic r);
		#8 sda_low = !b;
		#16 scl = 1'b1;
		#12 r = sda;
		#12 scl = 1'b0;
	endtask : xbit
	task automatic start();
		#8 sda_low = 1'b0;
		#16 scl = 1'b1;
		#12 sda_low = 1'b1;
		#12 scl = 1'b0;
	endtask : start
	task automatic stop();
		#8 sda_low = 1'b1;
		#16 scl = 1'b1;
		#12 sda_low = 1'b0;
		#12;
	endtask : stop
	task automatic wb(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r);
		xbit(1'b1, r);
		a = !r;
	endtask : wb
	task automatic rb(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, d[i]);
		xbit(nack, r);
	endtask : rb
endmodule : tsi_bus_master

//--- dv/tsi_slave_tb_top.sv
// testbench of the two-wire slave port
`timescale 1ns/1ns
module tsi_slave_tb_top;
	import tsi_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [1:0]   strap = 2'h0;
	logic         scl, sda_low, sda_oe, sda_out, reg_req_valid, busy, ack;
	logic [7:0]   reg_rd_addr, rd;
	logic [15:0]  mem [256];
	tsi_reg_req_t reg_req;
	tsi_reg_req_t wq [$];
	int           n_errors = 0;
	int           compares = 0;
	wire          sda = !(sda_low || sda_oe);
	tsi_bus_master tsi_bus_master_i (.sda, .scl, .sda_low);
	tsi_slave tsi_slave_i (.ref_clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .reg_req, .reg_req_valid,
		.reg_rdata(mem[reg_rd_addr]), .reg_rd_addr, .busy);
	initial for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};
	always @(posedge ref_clk) if (reg_req_valid === 1'b1) begin
		mem[reg_req.addr] <= reg_req.data;
		wq.push_back(reg_req);
	end
	initial forever #2 ref_clk = !ref_clk;
	task chk(input string nm, input logic [24:0] e, input logic [24:0] s);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task go();
		tsi_bus_master_i.start();
	endtask : go
	task stp();
		tsi_bus_master_i.stop();
		#16;
	endtask : stp
	task wb(input logic [7:0] d);
		tsi_bus_master_i.wb(d, ack);
	endtask : wb
	task t_reset();
		chk("oe", 1'b0, sda_oe);
		chk("ptr", 8'h00, reg_rd_addr);
	endtask : t_reset
	task t_addr();
		for (int s = 0; s < 4; s++) begin
			strap = s[1:0];
			#40;
			go();
			wb({5'h0b, s[1:0], 1'b0});
			chk("ack", 1'b1, ack);
			stp();
			go();
			wb({5'h0b, ~s[1:0], 1'b0});
			chk("nack", 1'b0, ack);
			wb({5'h0b, s[1:0], 1'b0});
			chk("idle", 1'b0, ack);
			stp();
			go();
			wb({5'h0a, s[1:0], 1'b0});
			chk("fixed", 1'b0, ack);
			stp();
		end
	endtask : t_addr
	// odd trailing byte on purpose: the unpaired high half must vanish
	task t_write();
		go();
		wb(8'h5e);
		wb(8'h10);
		for (int i = 0; i < 5; i++) begin
			wb(8'h12 + 8'(i * 8'h22));
			chk("wack", 1'b1, ack);
		end
		stp();
		chk("nwr", 25'd2, 25'(wq.size()));
		chk("w0", {1'b1, 8'h10, 16'h1234}, wq[0]);
		chk("w1", {1'b1, 8'h11, 16'h5678}, wq[1]);
		chk("ptr", 8'h12, reg_rd_addr);
		chk("busy", 1'b0, busy);
		wq.delete();
	endtask : t_write
	task t_max();
		go();
		wb(8'h5e);
		wb(8'hff);
		wb(8'haa);
		wb(8'hbb);
		stp();
		chk("drop", 25'd0, 25'(wq.size()));
		chk("top", 8'hff, reg_rd_addr);
	endtask : t_max
	task t_rd_sr();
		go();
		wb(8'h5e);
		wb(8'hfe);
		go();
		wb(8'h5f);
		chk("rack", 1'b1, ack);
		for (int i = 0; i < 6; i++) begin
			logic [15:0] e;
			e = (i < 2) ? 16'h01fe : 16'h00ff;
			tsi_bus_master_i.rb(i == 5, rd);
			chk("rd", i[0] ? e[7:0] : e[15:8], rd);
		end
		stp();
	endtask : t_rd_sr
	task t_rd_p();
		go();
		wb(8'h5e);
		wb(8'h10);
		stp(); // pointer-only write
		go();
		wb(8'h5f);
		for (int i = 0; i < 4; i++) begin
			tsi_bus_master_i.rb(i == 3, rd);
			chk("seq", 8'h12 + 8'(i * 8'h22), rd);
		end
		stp();
	endtask : t_rd_p
	task close_out();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		#40;
		t_reset();
		t_addr();
		t_write();
		t_max();
		t_rd_sr();
		t_rd_p();
		close_out();
	end
endmodule : tsi_slave_tb_top
